// ---- inc/dssr_pkg.sv ----
// Constants and operation codes shared by the DSP shift, saturate and round unit.
package dssr_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W     = 32;
	localparam int HALF_W     = 16;
	localparam int WORD_CNT_W = 5;
	localparam int HALF_CNT_W = 4;
	localparam int OP_W       = 3;

	// ----------------------------------------------------------------
	// Saturation limits and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] WORD_MAX_POS = 32'h7fff_ffff;
	localparam logic [31:0] WORD_MAX_NEG = 32'h8000_0000;
	localparam logic [31:0] RESULT_RST   = 32'h0000_0000;
	localparam logic        FLAG_RST     = 1'b0;

	// Position of the shift overflow flag inside the DSP control register.
	localparam int OUFLAG_SHIFT_BIT = 22;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [OP_W-1:0] {
		SHIFT_LEFT_VAR_SAT_WORD,
		SHIFT_RIGHT_ARITH_PAIR_HALF,
		SHIFT_RIGHT_ARITH_ROUND_PAIR_HALF,
		SHIFT_RIGHT_ARITH_VAR_PAIR_HALF,
		SHIFT_RIGHT_ARITH_VAR_ROUND_PAIR_HALF,
		SHIFT_RIGHT_ARITH_ROUND_WORD
	} dssr_op_t;

endpackage

// ---- rtl/dssr_half_shift.sv ----
// One 16-bit lane of the paired-halfword arithmetic right shifter.
`timescale 1ns/1ns

module dssr_half_shift (
	// Operand lane
	input  logic [15:0] i_value,
	input  logic [3:0]  i_count,
	input  logic        i_round,
	// Shifted lane
	output logic [15:0] o_result
);

	// ----------------------------------------------------------------
	// Lane arithmetic
	// ----------------------------------------------------------------
	// One guard bit keeps the rounding add from wrapping a positive
	// maximum into a negative value; the lane never sees its neighbour.
	logic [16:0] ext;
	logic [16:0] bias;
	logic [16:0] sum;
	logic [16:0] shifted;

	always_comb begin
		ext = {i_value[15], i_value};
		if (i_round && (i_count != 4'h0)) begin
			bias = 17'h0_0001 << (i_count - 4'h1);
		end else begin
			bias = 17'h0_0000;
		end
		sum      = ext + bias;
		shifted  = $signed(sum) >>> i_count;
		o_result = shifted[15:0];
	end

endmodule // dssr_half_shift

// ---- rtl/dssr_unit.sv ----
// Single-cycle DSP shift unit with saturation, rounding and overflow flag.
`timescale 1ns/1ns

module dssr_unit (
	// Clock, reset, enable
	input  logic        i_clk_sys,
	input  logic        i_reset,
	input  logic        i_clk_en,
	// Issue from the core
	input  logic        i_valid,
	input  logic [2:0]  i_op,
	input  logic        i_dsp_enabled,
	input  logic [31:0] i_shift_source_operand,
	input  logic [31:0] i_value_operand,
	input  logic [4:0]  i_shift_amount_immediate,
	// Core write to the shift overflow flag
	input  logic        i_flag_load,
	input  logic        i_flag_value,
	// Result to write back
	output logic        o_valid,
	output logic [31:0] o_result,
	// Exceptions
	output logic        o_excp_reserved,
	output logic        o_excp_dsp_disabled,
	// Overflow flag, bit 22 of the DSP control register
	output logic        o_ovf_event,
	output logic        o_ovf_flag
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	dssr_pkg::dssr_op_t op;
	logic               legal;
	logic               is_sat;
	logic               is_pair;
	logic               pair_round;
	logic               pair_var;
	logic               is_word_rnd;

	always_comb begin
		op          = dssr_pkg::dssr_op_t'(i_op);
		legal       = 1'b1;
		is_sat      = 1'b0;
		is_pair     = 1'b0;
		pair_round  = 1'b0;
		pair_var    = 1'b0;
		is_word_rnd = 1'b0;
		case (op)
			dssr_pkg::SHIFT_LEFT_VAR_SAT_WORD: begin
				is_sat = 1'b1;
			end
			dssr_pkg::SHIFT_RIGHT_ARITH_PAIR_HALF: begin
				is_pair = 1'b1;
			end
			dssr_pkg::SHIFT_RIGHT_ARITH_ROUND_PAIR_HALF: begin
				is_pair    = 1'b1;
				pair_round = 1'b1;
			end
			dssr_pkg::SHIFT_RIGHT_ARITH_VAR_PAIR_HALF: begin
				is_pair  = 1'b1;
				pair_var = 1'b1;
			end
			dssr_pkg::SHIFT_RIGHT_ARITH_VAR_ROUND_PAIR_HALF: begin
				is_pair    = 1'b1;
				pair_round = 1'b1;
				pair_var   = 1'b1;
			end
			dssr_pkg::SHIFT_RIGHT_ARITH_ROUND_WORD: begin
				is_word_rnd = 1'b1;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	// Exceptions come only from decode and enable, never from operand
	// values; an unknown code outranks the disable check.
	logic issue;
	logic raise_reserved;
	logic raise_disabled;
	logic execute;

	assign issue          = i_clk_en && i_valid;
	assign raise_reserved = issue && !legal;
	assign raise_disabled = issue && legal && !i_dsp_enabled;
	assign execute        = issue && legal && i_dsp_enabled;

	// ----------------------------------------------------------------
	// Saturating variable left shift of a word
	// ----------------------------------------------------------------
	logic [4:0]  sat_cnt;
	logic [31:0] sat_shl;
	logic [31:0] sat_back;
	logic        sat_ovf;
	logic [31:0] sat_res;

	always_comb begin
		sat_cnt  = i_shift_source_operand[4:0];
		sat_shl  = i_value_operand << sat_cnt;
		// Shifting back arithmetically restores the operand only when
		// every bit lost matched the sign.
		sat_back = $signed(sat_shl) >>> sat_cnt;
		sat_ovf  = (sat_cnt != 5'h00) && (sat_back != i_value_operand);
		if (!sat_ovf) begin
			sat_res = sat_shl;
		end else if (i_value_operand[31]) begin
			sat_res = dssr_pkg::WORD_MAX_NEG;
		end else begin
			sat_res = dssr_pkg::WORD_MAX_POS;
		end
	end

	// ----------------------------------------------------------------
	// Paired halfword arithmetic right shifts
	// ----------------------------------------------------------------
	logic [3:0]  pair_cnt;
	logic [15:0] hi_res;
	logic [15:0] lo_res;

	always_comb begin
		if (pair_var) begin
			pair_cnt = i_shift_source_operand[3:0];
		end else begin
			pair_cnt = i_shift_amount_immediate[3:0];
		end
	end

	dssr_half_shift u_hi (
		.i_value  (i_value_operand[31:16]),
		.i_count  (pair_cnt),
		.i_round  (pair_round),
		.o_result (hi_res)
	);

	dssr_half_shift u_lo (
		.i_value  (i_value_operand[15:0]),
		.i_count  (pair_cnt),
		.i_round  (pair_round),
		.o_result (lo_res)
	);

	// ----------------------------------------------------------------
	// Rounded arithmetic right shift of a word
	// ----------------------------------------------------------------
	logic [4:0]  wrd_cnt;
	logic [32:0] wrd_bias;
	logic [32:0] wrd_sum;
	logic [32:0] wrd_shr;

	always_comb begin
		wrd_cnt = i_shift_amount_immediate;
		if (wrd_cnt != 5'h00) begin
			wrd_bias = 33'h0_0000_0001 << (wrd_cnt - 5'h01);
		end else begin
			wrd_bias = 33'h0_0000_0000;
		end
		wrd_sum = {i_value_operand[31], i_value_operand} + wrd_bias;
		wrd_shr = $signed(wrd_sum) >>> wrd_cnt;
	end

	// ----------------------------------------------------------------
	// Result select and registers
	// ----------------------------------------------------------------
	logic [31:0] result_nxt;

	always_comb begin
		if (is_sat) begin
			result_nxt = sat_res;
		end else if (is_pair) begin
			result_nxt = {hi_res, lo_res};
		end else if (is_word_rnd) begin
			result_nxt = wrd_shr[31:0];
		end else begin
			result_nxt = o_result;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_result <= dssr_pkg::RESULT_RST;
		end else if (execute) begin
			o_result <= result_nxt;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_valid             <= 1'b0;
			o_excp_reserved     <= 1'b0;
			o_excp_dsp_disabled <= 1'b0;
			o_ovf_event         <= 1'b0;
		end else if (i_clk_en) begin
			o_valid             <= execute;
			o_excp_reserved     <= raise_reserved;
			o_excp_dsp_disabled <= raise_disabled;
			o_ovf_event         <= execute && is_sat && sat_ovf;
		end
	end

	// The flag is sticky: an overflow in the same cycle as a core write
	// wins, so a clearing write cannot hide a fresh overflow.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_ovf_flag <= dssr_pkg::FLAG_RST;
		end else if (execute && is_sat && sat_ovf) begin
			o_ovf_flag <= 1'b1;
		end else if (i_clk_en && i_flag_load) begin
			o_ovf_flag <= i_flag_value;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	sequence sat_issue_s;
		execute && is_sat;
	endsequence

	sequence sat_ovf_s;
		sat_issue_s ##0 sat_ovf;
	endsequence

	sequence right_issue_s;
		execute && (is_pair || is_word_rnd) && !i_flag_load;
	endsequence

	sat_high_ignored_a: assert property (
		sat_issue_s ##0 (i_shift_source_operand[4:0] == 5'h00) |=>
			o_result == $past(i_value_operand) && !o_ovf_event)
		else $error("count zero left shift altered operand");

	sat_pos_clamp_a: assert property (
		sat_ovf_s ##0 !i_value_operand[31] |=>
			o_result == 32'h7fff_ffff)
		else $error("positive overflow not clamped to max");

	sat_neg_clamp_a: assert property (
		sat_ovf_s ##0 i_value_operand[31] |=>
			o_result == 32'h8000_0000)
		else $error("negative overflow not clamped to min");

	sat_flag_set_a: assert property (
		sat_issue_s ##0 (i_value_operand == 32'h4000_0000) ##0
			(sat_cnt == 5'h01) |=> o_ovf_event && o_ovf_flag)
		else $error("overflow did not set the flag");

	sat_no_ovf_a: assert property (
		sat_issue_s ##0 (i_value_operand == 32'hffff_ffff) |=>
			!o_ovf_event && o_result == ($past(i_value_operand) <<
			$past(sat_cnt)))
		else $error("sign-only shift flagged as overflow");

	flag_set_wins_a: assert property (
		sat_ovf_s ##0 i_flag_load ##0 !i_flag_value |=>
			o_ovf_flag ##1 ($stable(o_ovf_flag) || $past(i_flag_load) ||
			$past(execute)))
		else $error("clear beat a same-cycle overflow");

	excp_cause_a: assert property (
		o_excp_reserved || o_excp_dsp_disabled |->
			!o_valid && !o_ovf_event && $stable(o_result))
		else $error("exception cycle also wrote a result");

	excp_dis_cause_a: assert property (
		issue && legal && !i_dsp_enabled |=>
			o_excp_dsp_disabled && !o_excp_reserved)
		else $error("disabled unit did not raise its exception");

	pair_sign_fill_a: assert property (
		execute && is_pair && !pair_round |=>
			o_result[31] == $past(i_value_operand[31]) &&
			o_result[15] == $past(i_value_operand[15]))
		else $error("pair shift lost a half's sign");

	pair_imm_zero_a: assert property (
		execute && is_pair && !pair_var &&
			(i_shift_amount_immediate[3:0] == 4'h0) |=>
			o_result == $past(i_value_operand))
		else $error("fixed pair shift by zero altered operand");

	pair_no_carry_a: assert property (
		execute && pair_round && (pair_cnt != 4'h0) &&
			(i_value_operand == 32'h0000_ffff) |=>
			o_result == 32'h0000_0000)
		else $error("rounding carry crossed between halves");

	pair_var_cnt_a: assert property (
		execute && pair_var && (i_shift_source_operand[3:0] == 4'h0) |=>
			o_result == $past(i_value_operand))
		else $error("variable pair shift used upper count bits");

	word_round_a: assert property (
		execute && is_word_rnd && (wrd_cnt == 5'h1f) &&
			(i_value_operand == 32'h8000_0000) |=>
			o_result == 32'hffff_ffff)
		else $error("word round shift lost sign fill");

	word_zero_a: assert property (
		execute && is_word_rnd && (wrd_cnt == 5'h00) |=>
			o_result == $past(i_value_operand))
		else $error("rounding by zero altered operand");

	word_half_up_a: assert property (
		execute && is_word_rnd && (wrd_cnt == 5'h01) &&
			(i_value_operand == 32'h0000_0003) |=>
			o_result == 32'h0000_0002)
		else $error("word round shift wrong at count one");

	right_flag_hold_a: assert property (
		right_issue_s |=> $stable(o_ovf_flag) && !o_ovf_event)
		else $error("right shift changed the overflow flag");

endmodule // dssr_unit

// ---- dv/dssr_core_model.sv ----
// Core-side model that issues one shift operation and waits for its answer.
`timescale 1ns/1ns

module dssr_core_model (
	// Clock
	input  logic        i_clk_sys,
	// Issue to the unit
	output logic        o_valid,
	output logic [2:0]  o_op,
	output logic [31:0] o_src,
	output logic [31:0] o_val,
	output logic [4:0]  o_imm,
	// Answer seen from the unit
	input  logic        i_answer
);

	initial begin
		o_valid = 1'b0;
		o_op    = 3'h0;
		o_src   = 32'h0000_0000;
		o_val   = 32'h0000_0000;
		o_imm   = 5'h00;
	end

	// Operands are inverted once released, so a unit that samples them late
	// sees wrong data instead of a stale copy of the right one.
	task automatic issue(input logic [2:0] op, input logic [31:0] src,
		input logic [31:0] val, input logic [4:0] imm, output logic ok);
		int n;
		@(posedge i_clk_sys);
		o_valid <= 1'b1;
		o_op    <= op;
		o_src   <= src;
		o_val   <= val;
		o_imm   <= imm;
		@(posedge i_clk_sys);
		o_valid <= 1'b0;
		o_op    <= ~op;
		o_src   <= ~src;
		o_val   <= ~val;
		o_imm   <= ~imm;
		#1;
		n = 0;
		while (i_answer !== 1'b1 && n < 4) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		ok = (i_answer === 1'b1);
	endtask

endmodule // dssr_core_model

// ---- dv/testbench.sv ----
// Self-checking testbench for the DSP shift, saturate and round unit.
`timescale 1ns/1ns

module testbench;
	logic        clk;
	logic        rst;
	logic        ce;
	logic        dsp_en;
	logic        fl_load;
	logic        fl_val;
	logic        iv;
	logic [2:0]  op;
	logic [31:0] src;
	logic [31:0] val;
	logic [4:0]  imm;
	logic        valid;
	logic [31:0] result;
	logic        ex_res;
	logic        ex_dis;
	logic        ovf_ev;
	logic        ovf_flag;
	logic        answer;
	int          errors;
	int          checks;

	assign answer = valid | ex_res | ex_dis;

	dssr_unit uut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(ce),
		.i_valid(iv), .i_op(op), .i_dsp_enabled(dsp_en),
		.i_shift_source_operand(src), .i_value_operand(val),
		.i_shift_amount_immediate(imm), .i_flag_load(fl_load),
		.i_flag_value(fl_val), .o_valid(valid), .o_result(result),
		.o_excp_reserved(ex_res), .o_excp_dsp_disabled(ex_dis),
		.o_ovf_event(ovf_ev), .o_ovf_flag(ovf_flag));

	dssr_core_model core (.i_clk_sys(clk), .o_valid(iv), .o_op(op),
		.o_src(src), .o_val(val), .o_imm(imm), .i_answer(answer));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [15:0] half_x(logic [15:0] v, logic [3:0] c,
		logic r);
		logic signed [16:0] t;
		t = $signed({v[15], v});
		if (r && c != 4'h0)
			t = t + (17'sd1 <<< (c - 4'd1));
		return 16'(t >>> c);
	endfunction

	function automatic logic [31:0] word_x(logic [31:0] v, logic [4:0] c);
		logic signed [32:0] t;
		t = $signed({v[31], v});
		if (c != 5'h00)
			t = t + (33'sd1 <<< (c - 5'd1));
		return 32'(t >>> c);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("Totals: checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic run(input logic [2:0] o, input logic [31:0] s,
		input logic [31:0] v, input logic [4:0] i);
		logic ok;
		core.issue(o, s, v, i, ok);
		if (!ok) begin
			errors++;
			stop_test();
		end
	endtask

	// Decoy counts sit in the field that the operation must ignore.
	task automatic t_pair;
		logic [31:0] vs [4] = '{32'h7fff_8001, 32'h0001_ffff, 32'h8000_7fff,
			32'h0000_ffff};
		logic [3:0]  cs [4] = '{4'h0, 4'h1, 4'h7, 4'hf};
		logic        r;
		logic        vr;
		for (int o = 1; o <= 4; o++) begin
			r  = (o == 2 || o == 4);
			vr = (o >= 3);
			foreach (vs[a]) begin
				foreach (cs[b]) begin
					if (vr)
						run(3'(o), {28'hfff_fffe, cs[b]}, vs[a], {1'b0, ~cs[b]});
					else
						run(3'(o), {28'h0, ~cs[b]}, vs[a], {1'b1, cs[b]});
					chk(result, {half_x(vs[a][31:16], cs[b], r),
						half_x(vs[a][15:0], cs[b], r)});
					chk(32'({ex_res, ex_dis, ovf_ev, ovf_flag}), 32'h1);
				end
			end
		end
		$display("test pair shifts done");
	endtask

	task automatic t_word;
		logic [31:0] vs [4] = '{32'h7fff_ffff, 32'h8000_0000, 32'hffff_ffff,
			32'h1234_5678};
		logic [4:0]  cs [4] = '{5'h00, 5'h01, 5'h10, 5'h1f};
		foreach (vs[a]) begin
			foreach (cs[b]) begin
				run(3'h5, 32'hffff_ffff, vs[a], cs[b]);
				chk(result, word_x(vs[a], cs[b]));
				chk(32'({ex_res, ex_dis, ovf_ev, ovf_flag}), 32'h1);
			end
		end
		$display("test rounded word done");
	endtask

	task automatic t_sat;
		logic [31:0] ss [5] = '{32'hffff_ffe4, 32'h0000_0001, 32'h0000_001f,
			32'h0000_0020, 32'h0000_0002};
		logic [31:0] vs [5] = '{32'h0123_4567, 32'h4000_0000, 32'hffff_ffff,
			32'h8000_0001, 32'hbfff_ffff};
		logic [31:0] xs [5] = '{32'h1234_5670, dssr_pkg::WORD_MAX_POS,
			32'h8000_0000, 32'h8000_0001, dssr_pkg::WORD_MAX_NEG};
		logic        eo [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		logic        f;
		f = 1'b0;
		foreach (ss[a]) begin
			run(3'h0, ss[a], vs[a], 5'h00);
			f = f | eo[a];
			chk(result, xs[a]);
			chk(32'({ovf_ev, ovf_flag}), 32'({eo[a], f}));
			chk(32'({ex_res, ex_dis}), 32'h0);
		end
		$display("test saturating shift done");
	endtask

	task automatic t_excp;
		logic [31:0] keep;
		fl_load <= 1'b1;
		fl_val  <= 1'b0;
		@(posedge clk);
		fl_load <= 1'b0;
		#1;
		chk(32'(ovf_flag), 32'h0);
		keep = result;
		for (int o = 6; o <= 7; o++) begin
			run(3'(o), 32'h1, 32'h4000_0000, 5'h01);
			chk(32'({valid, ex_res, ex_dis, ovf_flag}), 32'h4);
			chk(result, keep);
		end
		dsp_en <= 1'b0;
		run(3'h0, 32'h1, 32'h4000_0000, 5'h01);
		chk(32'({valid, ex_res, ex_dis, ovf_flag}), 32'h2);
		chk(result, keep);
		run(3'h7, 32'h1, 32'h4000_0000, 5'h01);
		chk(32'({valid, ex_res, ex_dis, ovf_flag}), 32'h4);
		dsp_en <= 1'b1;
		// An overflow and a clearing write in one cycle: the set must win.
		fork
			run(3'h0, 32'h1, 32'h4000_0000, 5'h00);
			begin
				@(posedge clk);
				fl_load <= 1'b1;
				fl_val  <= 1'b0;
				@(posedge clk);
				fl_load <= 1'b0;
			end
		join
		chk(32'({valid, ovf_ev, ovf_flag}), 32'h7);
		$display("test exceptions done");
	endtask

	// Enable low must hold every output, the one-cycle pulse included.
	task automatic t_freeze;
		run(3'h5, 32'h0, 32'h0000_0003, 5'h01);
		chk(result, word_x(32'h0000_0003, 5'h01));
		ce <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		#1;
		chk(32'(valid), 32'h1);
		chk(result, word_x(32'h0000_0003, 5'h01));
		@(posedge clk);
		#1;
		chk(32'(valid), 32'h0);
		$display("test clock enable done");
	endtask

	initial begin
		rst     = 1'b1;
		dsp_en  = 1'b1;
		ce      = 1'b1;
		fl_load = 1'b0;
		fl_val  = 1'b0;
		errors  = 0;
		checks  = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_sat();
		t_pair();
		t_word();
		t_excp();
		t_freeze();
		stop_test();
	end

endmodule // testbench
